// file: rtl/osc_ctrl_defines.svh
// register offsets, field positions, reset values and timing counts of the oscillator controller
// assumes a single 100 MHz mclk domain; included by the top module and the testbench
// Operation
// - controller keeps working in sleep modes while its source clock runs; interrupts wake
// - writes reaching the locked-loop domain are synchronized across clock domains
// - every writable register except interrupt flags can be write-protected
// - debug halt or external debugger access bypasses write protection
// - operation continues unchanged while cpu is halted in debug
// - after reset external oscillator is off and its pins are free
// - crystal mode owns both pins; external clock mode owns input pin only
// - writing 1 to external enable starts the external oscillator
// - crystal select 1 runs crystal, 0 enables clock input on input pin
// - software sets drive level; auto amplitude bit enables automatic amplitude control
// - external oscillator runs per enable, sleep mode, run-in-standby and on-demand
// - after reset or wake from off, output masked for selected start-up time
// - ready status set when stable; rising edge raises interrupt if enabled
// - rc oscillator produces 4, 8, 12 or 16 MHz per frequency choice
// - writing 1 enables rc oscillator, writing 0 disables it
// - rc clock output only once rc ready status reads 1
// - after reset rc oscillator is enabled at 4 MHz as default source
// - rc oscillator follows the same sleep behaviour table as external oscillator
// - status register gathers oscillator status; enabled ones wake from standby
// - status changes trigger interrupts via enable set, enable clear and flag registers
`ifndef OSC_CTRL_DEFINES_SVH
`define OSC_CTRL_DEFINES_SVH

`define ADDR_W 4
`define OFS_INTERRUPT_ENABLE_CLEAR 4'h0
`define OFS_INTERRUPT_ENABLE_SET 4'h1
`define OFS_INTERRUPT_FLAGS 4'h2
`define OFS_STATUS 4'h3
`define OFS_EXT_CTRL 4'h4
`define OFS_RC_CTRL 4'h5
`define OFS_LOOP_CTRL 4'h6
`define OFS_PROTECT 4'h7

// interrupt and status bit positions
`define BIT_EXT_READY 0
`define BIT_RC_READY 1
`define IRQ_W 2

// external control register fields
`define EXT_ENABLE 1
`define EXT_XTAL 2
`define EXT_RUN_IN_STANDBY 6
`define EXT_ON_DEMAND_A 7
`define EXT_GAIN_LO 8
`define EXT_AMPC 11
`define EXT_START_LO 12
`define EXT_CTRL_RESET 16'h0080

// rc control register fields
`define RC_ENABLE 1
`define RC_FREQ_LO 2
`define RC_RUN_IN_STANDBY 6
`define RC_ON_DEMAND_A 7
`define RC_CTRL_RESET 8'h82

// start-up mask base and rc start and stop times, in ns and in mclk cycles
`define START_UNIT_NS 1000
`define START_UNIT_CYC ((`START_UNIT_NS + 9) / 10)
`define RC_START_NS 100
`define RC_START_CYC ((`RC_START_NS + 9) / 10)
`define RC_STOP_CYC 4

`endif

// file: rtl/osc_ctrl_pkg.sv
// types shared by the oscillator controller
// assumes osc_ctrl_defines.svh is on the include path
package osc_ctrl_pkg;
    typedef enum logic [1:0] {OSC_OFF, OSC_START, OSC_RUN, OSC_STOP} osc_state_e;
    typedef enum logic [1:0] {CPU_ACTIVE, CPU_IDLE, CPU_STANDBY} cpu_mode_e;
    typedef struct packed {
        logic enable;
        logic xtal;
        logic run_in_standby;
        logic on_demand_a;
        logic [2:0] gain;
        logic ampc;
        logic [3:0] startup;
    } ext_cfg_s;
    typedef struct packed {
        logic enable;
        logic [1:0] freq;
        logic run_in_standby;
        logic on_demand_a;
    } rc_cfg_s;
    typedef struct packed {
        logic in_oe_n;
        logic out_oe_n;
        logic xtal_drive;
        logic [2:0] gain;
        logic ampc;
    } pin_ctl_s;
endpackage

// file: rtl/osc_ctrl.sv
// oscillator controller: external oscillator and rc oscillator control, status and interrupt
// assumes a register port master on mclk and an external oscillator reporting a raw ready level
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "osc_ctrl_defines.svh"
module osc_ctrl
    import osc_ctrl_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // protection and debug
    input wire logic protect_lock,
    input wire logic cpu_debug_halt,
    input wire logic ext_debugger,
    // system context
    input wire logic [1:0] cpu_mode,
    input wire logic ext_clk_request,
    input wire logic rc_clk_request,
    input wire logic ext_osc_stable,
    // oscillator controls
    output logic ext_osc_run,
    output logic ext_clk_gate,
    output pin_ctl_s pin_ctl,
    output logic rc_osc_run,
    output logic [1:0] rc_freq_sel,
    output logic rc_clk_gate,
    // locked-loop domain write handshake
    output logic [15:0] loop_cfg,
    output logic loop_cfg_toggle,
    // interrupt and wake
    output logic irq,
    output logic wake_req
);

    logic rst_s1_reg;
    logic rst_s2_reg;
    ext_cfg_s ext_reg;
    rc_cfg_s rc_reg;
    logic [`IRQ_W-1:0] inten_reg;
    logic [`IRQ_W-1:0] flag_reg;
    logic [`IRQ_W-1:0] status_prev_reg;
    logic [`IRQ_W-1:0] status;
    logic [15:0] loop_reg;
    logic loop_tog_reg;
    logic lock_reg;
    logic [15:0] rdata_reg;
    osc_state_e ext_state_reg;
    osc_state_e rc_state_reg;
    logic [21:0] ext_cnt_reg;
    logic [7:0] rc_cnt_reg;
    logic ext_ready_reg;
    logic rc_ready_reg;
    logic ext_want;
    logic rc_want;
    logic wr_ok;
    logic [21:0] ext_start_cycles;

    // run decision shared by both oscillators
    function automatic logic osc_wanted(input logic en, input logic rs, input logic od,
                                        input logic [1:0] mode, input logic req);
        if (!en) begin
            osc_wanted = 1'b0;
        end else if (mode == CPU_STANDBY && !rs) begin
            osc_wanted = req;
        end else begin
            osc_wanted = od ? req : 1'b1;
        end
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    assign ext_want = osc_wanted(ext_reg.enable, ext_reg.run_in_standby, ext_reg.on_demand_a,
                                 cpu_mode, ext_clk_request);
    assign rc_want = osc_wanted(rc_reg.enable, rc_reg.run_in_standby, rc_reg.on_demand_a,
                                cpu_mode, rc_clk_request);
    // debug halt and debugger accesses bypass protection; nothing is frozen in debug
    assign wr_ok = wr && (!lock_reg || cpu_debug_halt || ext_debugger);
    assign status = {rc_ready_reg, ext_ready_reg};
    // read data come straight from their register, zero outside the read slot
    assign rdata = rdata_reg;
    // start-up time doubles per step of the settle-delay field; 22 bits hold the longest
    assign ext_start_cycles = 22'(`START_UNIT_CYC) << ext_reg.startup;

    // protection lock register: writable only while unlocked or via debug
    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            lock_reg <= 1'b0;
        end else if (wr_ok && addr == `OFS_PROTECT) begin
            lock_reg <= wdata[0] | protect_lock;
        end else if (protect_lock) begin
            lock_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            ext_reg <= '{enable: 1'b0, xtal: 1'b0, run_in_standby: 1'b0, on_demand_a: 1'b1,
                         gain: 3'h0, ampc: 1'b0, startup: 4'h0};
        end else if (wr_ok && addr == `OFS_EXT_CTRL) begin
            ext_reg.enable <= wdata[`EXT_ENABLE];
            ext_reg.xtal <= wdata[`EXT_XTAL];
            ext_reg.run_in_standby <= wdata[`EXT_RUN_IN_STANDBY];
            ext_reg.on_demand_a <= wdata[`EXT_ON_DEMAND_A];
            ext_reg.gain <= wdata[`EXT_GAIN_LO +: 3];
            ext_reg.ampc <= wdata[`EXT_AMPC];
            ext_reg.startup <= wdata[`EXT_START_LO +: 4];
        end
    end

    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            rc_reg <= '{enable: 1'b1, freq: 2'h0, run_in_standby: 1'b0, on_demand_a: 1'b1};
        end else if (wr_ok && addr == `OFS_RC_CTRL) begin
            rc_reg.enable <= wdata[`RC_ENABLE];
            rc_reg.freq <= wdata[`RC_FREQ_LO +: 2];
            rc_reg.run_in_standby <= wdata[`RC_RUN_IN_STANDBY];
            rc_reg.on_demand_a <= wdata[`RC_ON_DEMAND_A];
        end
    end

    // locked-loop config: data held stable, toggle signals a new write to the far domain
    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            loop_reg <= 16'h0000;
            loop_tog_reg <= 1'b0;
        end else if (wr_ok && addr == `OFS_LOOP_CTRL) begin
            loop_reg <= wdata;
            loop_tog_reg <= ~loop_tog_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            inten_reg <= 2'h0;
        end else if (wr_ok && addr == `OFS_INTERRUPT_ENABLE_SET) begin
            inten_reg <= inten_reg | wdata[`IRQ_W-1:0];
        end else if (wr_ok && addr == `OFS_INTERRUPT_ENABLE_CLEAR) begin
            inten_reg <= inten_reg & ~wdata[`IRQ_W-1:0];
        end
    end

    // flags: rising status sets, write-one clears, set wins; never write-protected
    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            flag_reg <= 2'h0;
            status_prev_reg <= 2'h0;
        end else begin
            status_prev_reg <= status;
            if (wr && addr == `OFS_INTERRUPT_FLAGS) begin
                flag_reg <= (flag_reg & ~wdata[`IRQ_W-1:0]) | (status & ~status_prev_reg);
            end else begin
                flag_reg <= flag_reg | (status & ~status_prev_reg);
            end
        end
    end

    // external oscillator: start-up mask on every start from off
    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            ext_state_reg <= OSC_OFF;
            ext_cnt_reg <= 22'h000000;
            ext_ready_reg <= 1'b0;
        end else begin
            case (ext_state_reg)
                OSC_OFF: begin
                    ext_ready_reg <= 1'b0;
                    if (ext_want) begin
                        ext_state_reg <= OSC_START;
                        ext_cnt_reg <= 22'h000000;
                    end
                end
                OSC_START: begin
                    if (!ext_want) begin
                        ext_state_reg <= OSC_OFF;
                    end else if (ext_cnt_reg >= ext_start_cycles - 22'h000001
                                 && ext_osc_stable) begin
                        ext_state_reg <= OSC_RUN;
                        ext_ready_reg <= 1'b1;
                    end else if (ext_cnt_reg < ext_start_cycles) begin
                        ext_cnt_reg <= ext_cnt_reg + 22'h000001;
                    end
                end
                OSC_RUN: begin
                    if (!ext_want) begin
                        ext_state_reg <= OSC_OFF;
                        ext_ready_reg <= 1'b0;
                    end
                end
                default: begin
                    ext_state_reg <= OSC_OFF;
                end
            endcase
        end
    end

    // rc oscillator: ready rises after start time, falls only once fully stopped
    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            rc_state_reg <= OSC_OFF;
            rc_cnt_reg <= 8'h00;
            rc_ready_reg <= 1'b0;
        end else begin
            case (rc_state_reg)
                OSC_OFF: begin
                    if (rc_want) begin
                        rc_state_reg <= OSC_START;
                        rc_cnt_reg <= 8'h00;
                    end
                end
                OSC_START: begin
                    if (rc_cnt_reg == 8'(`RC_START_CYC - 1)) begin
                        rc_state_reg <= OSC_RUN;
                        rc_ready_reg <= 1'b1;
                    end else begin
                        rc_cnt_reg <= rc_cnt_reg + 8'h01;
                    end
                end
                OSC_RUN: begin
                    if (!rc_want) begin
                        rc_state_reg <= OSC_STOP;
                        rc_cnt_reg <= 8'h00;
                    end
                end
                OSC_STOP: begin
                    if (rc_cnt_reg == 8'(`RC_STOP_CYC - 1)) begin
                        rc_state_reg <= OSC_OFF;
                        rc_ready_reg <= 1'b0;
                    end else begin
                        rc_cnt_reg <= rc_cnt_reg + 8'h01;
                    end
                end
                default: begin
                    rc_state_reg <= OSC_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            rdata_reg <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `OFS_INTERRUPT_ENABLE_CLEAR, `OFS_INTERRUPT_ENABLE_SET: rdata_reg <= {14'h0000, inten_reg};
                `OFS_INTERRUPT_FLAGS: rdata_reg <= {14'h0000, flag_reg};
                `OFS_STATUS: rdata_reg <= {14'h0000, status};
                `OFS_EXT_CTRL: rdata_reg <= {ext_reg.startup, ext_reg.ampc, ext_reg.gain,
                                             ext_reg.on_demand_a, ext_reg.run_in_standby, 3'h0,
                                             ext_reg.xtal, ext_reg.enable, 1'b0};
                `OFS_RC_CTRL: rdata_reg <= {8'h00, rc_reg.on_demand_a, rc_reg.run_in_standby,
                                            2'h0, rc_reg.freq, rc_reg.enable, 1'b0};
                `OFS_LOOP_CTRL: rdata_reg <= loop_reg;
                `OFS_PROTECT: rdata_reg <= {15'h0000, lock_reg};
                default: rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    // registered outputs
    always_ff @(posedge mclk or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            ext_osc_run <= 1'b0;
            ext_clk_gate <= 1'b0;
            pin_ctl <= '{in_oe_n: 1'b1, out_oe_n: 1'b1, xtal_drive: 1'b0, gain: 3'h0,
                         ampc: 1'b0};
            rc_osc_run <= 1'b0;
            rc_freq_sel <= 2'h0;
            rc_clk_gate <= 1'b0;
            loop_cfg <= 16'h0000;
            loop_cfg_toggle <= 1'b0;
            irq <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            ext_osc_run <= ext_state_reg != OSC_OFF;
            ext_clk_gate <= ext_ready_reg && ext_state_reg == OSC_RUN;
            pin_ctl.in_oe_n <= !ext_reg.enable;
            pin_ctl.out_oe_n <= !(ext_reg.enable && ext_reg.xtal);
            pin_ctl.xtal_drive <= ext_reg.enable && ext_reg.xtal;
            pin_ctl.gain <= ext_reg.gain;
            pin_ctl.ampc <= ext_reg.ampc;
            rc_osc_run <= rc_state_reg == OSC_START || rc_state_reg == OSC_RUN;
            rc_freq_sel <= rc_reg.freq;
            rc_clk_gate <= rc_ready_reg && rc_state_reg == OSC_RUN;
            loop_cfg <= loop_reg;
            loop_cfg_toggle <= loop_tog_reg;
            irq <= |(flag_reg & inten_reg);
            wake_req <= |(flag_reg & inten_reg);
        end
    end

endmodule // osc_ctrl

// file: verif/osc_ctrl_props.sv
// concurrent checks on the oscillator controller ports
// bound into osc_ctrl; sees only its ports
`timescale 1ns/100ps
module osc_ctrl_props
    import osc_ctrl_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic rd,
    input wire logic wr,
    input wire logic [15:0] rdata,
    // oscillator side
    input wire logic ext_osc_stable,
    input wire logic ext_osc_run,
    input wire logic ext_clk_gate,
    input wire pin_ctl_s pin_ctl,
    input wire logic rc_osc_run,
    input wire logic rc_clk_gate,
    input wire logic loop_cfg_toggle,
    // interrupt
    input wire logic irq,
    input wire logic wake_req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_rdata_quiet: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside its slot");
    a_pins_paired: assert property (!pin_ctl.out_oe_n |-> !pin_ctl.in_oe_n)
        else $error("output pin taken without input pin");
    a_reset_pins: assert property (disable iff (1'b0)
        $rose(rst_n) |-> pin_ctl.in_oe_n && pin_ctl.out_oe_n && !ext_osc_run)
        else $error("pins not free after reset");
    a_ext_mask: assert property ($rose(ext_clk_gate) |-> $past(ext_osc_run, 90))
        else $error("external clock released before start-up time");
    a_ext_stable: assert property ($rose(ext_clk_gate) |-> $past(ext_osc_stable))
        else $error("external clock released while unstable");
    a_rc_ready: assert property ($rose(rc_clk_gate) |-> $past(rc_osc_run, 2))
        else $error("rc clock released before ready");
    a_wake_irq: assert property (wake_req == irq)
        else $error("wake request differs from interrupt");
    a_loop_write: assert property ($changed(loop_cfg_toggle)
        |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
        else $error("loop handshake toggled without a write");
    a_irq_clear: assert property ($fell(irq)
        |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
        else $error("interrupt dropped without a write");
endmodule // osc_ctrl_props

bind osc_ctrl osc_ctrl_props osc_ctrl_props_inst (.mclk(mclk), .rst_n(rst_n), .rd(rd), .wr(wr),
    .rdata(rdata), .ext_osc_stable(ext_osc_stable), .ext_osc_run(ext_osc_run),
    .ext_clk_gate(ext_clk_gate), .pin_ctl(pin_ctl), .rc_osc_run(rc_osc_run),
    .rc_clk_gate(rc_clk_gate), .loop_cfg_toggle(loop_cfg_toggle), .irq(irq),
    .wake_req(wake_req));

// file: verif/osc_far_side.sv
// far side model: external oscillator core and clock-requesting peripherals
// assumes ext_osc_run powers the core; the bench says what peripherals want
`timescale 1ns/100ps
module osc_far_side #(
    parameter int STABLE_CYC = 20
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // bench commands
    input wire logic ext_want,
    input wire logic rc_want,
    // controller side
    input wire logic ext_osc_run,
    output logic ext_clk_request,
    output logic rc_clk_request,
    output logic ext_osc_stable
);
    int cnt;

    // core settles only after a stretch of power and loses it at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
        end else if (!ext_osc_run) begin
            cnt <= 0;
        end else if (cnt < STABLE_CYC) begin
            cnt <= cnt + 1;
        end
    end
    assign ext_osc_stable = (cnt == STABLE_CYC);
    assign ext_clk_request = ext_want;
    assign rc_clk_request = rc_want;
endmodule // osc_far_side

// file: verif/osc_ctrl_tb.sv
// self-checking bench for the oscillator controller
// drives register port and system context; osc_far_side plays the analog side
`timescale 1ns/100ps
`include "osc_ctrl_defines.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
    $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
`define WAITFOR(cond, n) begin int k; for (k = 0; k < (n) && !(cond); k++) @(posedge mclk); \
    if (!(cond)) begin error_cnt++; $display("unexpected wait exp 1 got 0"); \
    report_and_stop(); end end
module osc_ctrl_tb;
    import osc_ctrl_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic protect_lock = 1'b0;
    logic cpu_debug_halt = 1'b0;
    logic ext_debugger = 1'b0;
    logic [1:0] cpu_mode = 2'h0;
    logic ext_want = 1'b0;
    logic rc_want = 1'b1;
    logic [15:0] rdata, loop_cfg, rv;
    logic ext_osc_run, ext_clk_gate, rc_osc_run, rc_clk_gate, loop_cfg_toggle, irq, wake_req;
    logic ext_clk_request, rc_clk_request, ext_osc_stable;
    logic [1:0] rc_freq_sel;
    pin_ctl_s pin_ctl;
    int error_cnt = 0;
    int tests_run = 0;

    always #5 mclk = ~mclk;

    osc_ctrl osc_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .protect_lock(protect_lock), .cpu_debug_halt(cpu_debug_halt),
        .ext_debugger(ext_debugger), .cpu_mode(cpu_mode), .ext_clk_request(ext_clk_request),
        .rc_clk_request(rc_clk_request), .ext_osc_stable(ext_osc_stable),
        .ext_osc_run(ext_osc_run), .ext_clk_gate(ext_clk_gate), .pin_ctl(pin_ctl),
        .rc_osc_run(rc_osc_run), .rc_freq_sel(rc_freq_sel), .rc_clk_gate(rc_clk_gate),
        .loop_cfg(loop_cfg), .loop_cfg_toggle(loop_cfg_toggle), .irq(irq), .wake_req(wake_req));
    osc_far_side osc_far_side_inst (.mclk(mclk), .rst_n(rst_n), .ext_want(ext_want),
        .rc_want(rc_want), .ext_osc_run(ext_osc_run), .ext_clk_request(ext_clk_request),
        .rc_clk_request(rc_clk_request), .ext_osc_stable(ext_osc_stable));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [15:0] ex, input string nm);
        logic [15:0] d;
        rd_reg(a, d);
        `CHK(nm, ex, d)
    endtask
    // disable, confirm stopped, set frequency while off, then enable
    task automatic rc_set(input logic [15:0] v);
        wr_reg(`OFS_RC_CTRL, 16'h0000);
        rv = 16'hFFFF;
        for (int k = 0; k < 20 && rv[`BIT_RC_READY]; k++) begin
            rd_reg(`OFS_STATUS, rv);
        end
        `CHK("rc ready off", 1'b0, rv[`BIT_RC_READY])
        `CHK("rc off", 1'b0, rc_osc_run)
        wr_reg(`OFS_RC_CTRL, v & 16'hFFFD);
        wr_reg(`OFS_RC_CTRL, v);
        @(posedge mclk);
        `CHK("rc gate early", 1'b0, rc_clk_gate)
        `WAITFOR(rc_clk_gate, 40)
    endtask

    task automatic t_reset();
        chk_rd(`OFS_EXT_CTRL, `EXT_CTRL_RESET, "ext ctrl");
        `CHK("pins", 2'b11, {pin_ctl.in_oe_n, pin_ctl.out_oe_n})
        chk_rd(`OFS_RC_CTRL, `RC_CTRL_RESET, "rc ctrl");
        `CHK("rc freq", 2'h0, rc_freq_sel)
        `WAITFOR(rc_clk_gate, 40)
        `CHK("rc run", 1'b1, rc_osc_run)
        $display("test reset done");
    endtask
    task automatic t_ext();
        wr_reg(`OFS_EXT_CTRL, 16'h0F06);
        repeat (3) @(posedge mclk);
        `CHK("ext run", 1'b1, ext_osc_run)
        `CHK("xtal pins", 3'b001, {pin_ctl.in_oe_n, pin_ctl.out_oe_n, pin_ctl.xtal_drive})
        `CHK("gain", 4'hF, {pin_ctl.gain, pin_ctl.ampc})
        repeat (80) @(posedge mclk);
        `CHK("mask", 1'b0, ext_clk_gate)
        `WAITFOR(ext_clk_gate, 200)
        chk_rd(`OFS_STATUS, 16'h0003, "status");
        wr_reg(`OFS_EXT_CTRL, 16'h0002);
        repeat (2) @(posedge mclk);
        `CHK("clk pins", 3'b010, {pin_ctl.in_oe_n, pin_ctl.out_oe_n, pin_ctl.xtal_drive})
        wr_reg(`OFS_EXT_CTRL, 16'h0000);
        repeat (3) @(posedge mclk);
        `CHK("ext off", 3'b011, {ext_osc_run, pin_ctl.in_oe_n, pin_ctl.out_oe_n})
        $display("test external done");
    endtask
    task automatic t_sleep();
        logic [1:0] m;
        logic rs, od, rq, ex;
        for (int i = 0; i < 24; i++) begin
            {m, rs, od, rq} = 5'(i);
            ex = rq || (!od && (m != 2'h2 || rs));
            cpu_mode <= m;
            ext_want <= rq;
            rc_want <= rq;
            wr_reg(`OFS_EXT_CTRL, {8'h00, od, rs, 6'h02});
            wr_reg(`OFS_RC_CTRL, {8'h00, od, rs, 6'h02});
            // a stray rc start while mode and setting disagree needs start plus stop to clear
            repeat (14) @(posedge mclk);
            `CHK("ext sleep", ex, ext_osc_run)
            `CHK("rc sleep", ex, rc_osc_run)
        end
        cpu_mode <= 2'h0;
        ext_want <= 1'b0;
        rc_want <= 1'b1;
        wr_reg(`OFS_EXT_CTRL, 16'h0000);
        wr_reg(`OFS_RC_CTRL, 16'h0082);
        $display("test sleep done");
    endtask
    task automatic t_rc_freq();
        for (int f = 0; f < 4; f++) begin
            rc_set({12'h000, 2'(f), 2'b10});
            `CHK("rc freq", 2'(f), rc_freq_sel)
        end
        $display("test rc frequency done");
    endtask
    task automatic t_irq();
        wr_reg(`OFS_INTERRUPT_FLAGS, 16'h0003);
        wr_reg(`OFS_INTERRUPT_ENABLE_SET, 16'h0001);
        chk_rd(`OFS_INTERRUPT_ENABLE_CLEAR, 16'h0001, "enables");
        wr_reg(`OFS_EXT_CTRL, 16'h0006);
        `WAITFOR(irq, 300)
        `CHK("wake", 1'b1, wake_req)
        chk_rd(`OFS_INTERRUPT_FLAGS, 16'h0001, "flags");
        wr_reg(`OFS_INTERRUPT_FLAGS, 16'h0001);
        repeat (2) @(posedge mclk);
        `CHK("irq clr", 1'b0, irq)
        wr_reg(`OFS_INTERRUPT_ENABLE_CLEAR, 16'h0001);
        wr_reg(`OFS_EXT_CTRL, 16'h0000);
        repeat (5) @(posedge mclk);
        wr_reg(`OFS_EXT_CTRL, 16'h0006);
        `WAITFOR(ext_clk_gate, 300)
        repeat (3) @(posedge mclk);
        `CHK("irq masked", 1'b0, irq)
        chk_rd(`OFS_INTERRUPT_FLAGS, 16'h0001, "flag masked");
        wr_reg(`OFS_INTERRUPT_ENABLE_SET, 16'h0001);
        repeat (2) @(posedge mclk);
        `CHK("irq unmask", 1'b1, irq)
        wr_reg(`OFS_INTERRUPT_FLAGS, 16'h0003);
        wr_reg(`OFS_INTERRUPT_ENABLE_CLEAR, 16'h0001);
        wr_reg(`OFS_EXT_CTRL, 16'h0000);
        $display("test interrupt done");
    endtask
    task automatic t_protect();
        logic tg;
        rc_set(16'h0002);
        chk_rd(`OFS_INTERRUPT_FLAGS, 16'h0002, "rc flag");
        protect_lock <= 1'b1;
        @(posedge mclk);
        protect_lock <= 1'b0;
        wr_reg(`OFS_RC_CTRL, 16'h0082);
        chk_rd(`OFS_RC_CTRL, 16'h0002, "locked");
        wr_reg(`OFS_INTERRUPT_FLAGS, 16'h0002);
        chk_rd(`OFS_INTERRUPT_FLAGS, 16'h0000, "flag clear");
        cpu_debug_halt <= 1'b1;
        wr_reg(`OFS_RC_CTRL, 16'h0082);
        chk_rd(`OFS_RC_CTRL, 16'h0082, "debug halt");
        `CHK("halt run", 1'b1, rc_osc_run)
        cpu_debug_halt <= 1'b0;
        ext_debugger <= 1'b1;
        wr_reg(`OFS_RC_CTRL, 16'h0002);
        chk_rd(`OFS_RC_CTRL, 16'h0002, "debugger");
        wr_reg(`OFS_PROTECT, 16'h0000);
        ext_debugger <= 1'b0;
        tg = loop_cfg_toggle;
        wr_reg(`OFS_LOOP_CTRL, 16'hA5C3);
        repeat (3) @(posedge mclk);
        `CHK("loop data", 16'hA5C3, loop_cfg)
        `CHK("loop toggle", ~tg, loop_cfg_toggle)
        for (int a = 8; a < 16; a++) begin
            chk_rd(4'(a), 16'h0000, "unmapped");
        end
        $display("test protection done");
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_ext();
        t_sleep();
        t_rc_freq();
        t_irq();
        t_protect();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        $display("unexpected run length exp done got timeout");
        report_and_stop();
    end
endmodule // osc_ctrl_tb
